// ===== src/sst_defines.svh
// Purpose : Constants for the sixteen to one serial transmitter
// Assumes : Included by bare name from every design file that needs it
// Notes   : Definitions only
`ifndef SST_DEFINES_SVH
`define SST_DEFINES_SVH

// ----------------------------------------------------------------
// Word and divider figures
// ----------------------------------------------------------------
`define SST_WORD_W       16
`define SST_DIV_REF_622  16
`define SST_DIV_REF_155  64
`define SST_PHASES       4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SST_RST_BIT      1'h0
`define SST_RST_FLAG     1'h1

`endif

// ===== src/sst_pkg.sv
// Purpose : Shared types of the serial transmitter
// Assumes : Nothing
// Notes   : Constants live in sst_defines.svh
package sst_pkg;

    // Phase of the parallel side clock, in quarter periods
    typedef enum logic [1:0] {
        SST_PH_0,
        SST_PH_90,
        SST_PH_180,
        SST_PH_270
    } sst_phase_t;

    // Phase frequency detector state
    typedef enum logic [1:0] {
        SST_PFD_IDLE,
        SST_PFD_LEAD,
        SST_PFD_LAG
    } sst_pfd_state_t;

endpackage

// ===== src/sst_pfd.sv
// Purpose : Set/reset phase frequency detector
// Assumes : Edge inputs are one-cycle pulses on clock_in
// Notes   : Outputs come straight from flip-flops
`timescale 1ns/10ps
`include "sst_defines.svh"

module sst_pfd
    import sst_pkg::*;
(
    input  wire logic clock_in,
    input  wire logic rst_b_in,
    input  wire logic ref_edge_in,
    input  wire logic fb_edge_in,
    output logic      phase_up_pulse_out,
    output logic      phase_down_pulse_out
);

    sst_pfd_state_t state_ff;
    sst_pfd_state_t nxt_state;
    logic           up_ff;
    logic           nxt_up;
    logic           down_ff;
    logic           nxt_down;

    // ----------------------------------------------------------------
    // Set/reset behaviour
    // ----------------------------------------------------------------
    // Reference edge sets up, feedback edge sets down, the opposite edge clears whichever is set;
    // staying set across missed edges gives the frequency response
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            SST_PFD_IDLE:
            begin
                if (ref_edge_in && !fb_edge_in)
                    nxt_state = SST_PFD_LEAD;
                else if (fb_edge_in && !ref_edge_in)
                    nxt_state = SST_PFD_LAG;
            end
            SST_PFD_LEAD:
            begin
                if (fb_edge_in)
                    nxt_state = SST_PFD_IDLE;
            end
            SST_PFD_LAG:
            begin
                if (ref_edge_in)
                    nxt_state = SST_PFD_IDLE;
            end
            default:
                nxt_state = SST_PFD_IDLE;
        endcase
        nxt_up   = (nxt_state == SST_PFD_LEAD);
        nxt_down = (nxt_state == SST_PFD_LAG);
    end

    // State and output registers
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_ff <= SST_PFD_IDLE;
            up_ff    <= `SST_RST_BIT;
            down_ff  <= `SST_RST_BIT;
        end
        else
        begin
            state_ff <= nxt_state;
            up_ff    <= nxt_up;
            down_ff  <= nxt_down;
        end
    end

    assign phase_up_pulse_out   = up_ff;
    assign phase_down_pulse_out = down_ff;

endmodule

// ===== src/sst_serializer_top.sv
// Purpose : Sixteen to one serial transmitter with clock divider and PLL detector
// Assumes : clock_in stands for the bit rate oscillator; inputs synchronous to it
// Notes   : Analog tuning, loop filter and line levels are outside this logic
`timescale 1ns/10ps
`include "sst_defines.svh"

module sst_serializer_top
    import sst_pkg::*;
#(
    parameter int WORD_W  = `SST_WORD_W,
    parameter int REF_DIV = `SST_DIV_REF_622
)
(
    input  wire logic              clock_in,
    input  wire logic              rst_b_in,
    input  wire logic [WORD_W-1:0] parallel_lanes_in,
    input  wire logic [1:0]        clock_phase_select_in,
    input  wire logic              pll_reference_input_in,
    output logic                   serial_data_out,
    output logic                   serial_data_b_out,
    output logic                   parallel_side_clock_output_out,
    output logic                   parallel_side_clock_output_b_out,
    output logic                   word_load_out,
    output logic                   phase_up_pulse_out,
    output logic                   phase_down_pulse_out,
    output logic                   lock_loss_flag_out
);

    localparam int CNT_W  = $clog2(WORD_W);
    localparam int STEP   = WORD_W / `SST_PHASES;
    localparam int FB_W   = $clog2(REF_DIV);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    // Quarter phase steps need a power of two word of at least four bits
    if (WORD_W < 4 || (1 << CNT_W) != WORD_W)
        $error("sst_serializer_top: WORD_W must be a power of two, at least 4");
    if (REF_DIV != `SST_DIV_REF_622 && REF_DIV != `SST_DIV_REF_155)
        $error("sst_serializer_top: REF_DIV must be 16 or 64");

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_sync_ff;

    // Two stage release so no flop leaves reset on a marginal edge
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_meta_ff <= 1'h0;
            rst_sync_ff <= 1'h0;
        end
        else
        begin
            rst_meta_ff <= 1'h1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // Clock divider
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] bit_cnt_ff;
    logic [CNT_W-1:0] nxt_bit_cnt;
    logic [FB_W-1:0]  fb_cnt_ff;
    logic [FB_W-1:0]  nxt_fb_cnt;
    logic             load_now;
    logic             fb_edge;

    // Bit and feedback counters run side by side and feed every derived timing signal
    always_comb
    begin
        nxt_bit_cnt = CNT_W'(bit_cnt_ff + 1'b1);
        nxt_fb_cnt  = FB_W'(fb_cnt_ff + 1'b1);
        load_now    = (bit_cnt_ff == CNT_W'(WORD_W - 1));
        fb_edge     = (fb_cnt_ff == '0);
    end

    always_ff @(posedge clock_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            bit_cnt_ff <= '0;
            fb_cnt_ff  <= '0;
        end
        else
        begin
            bit_cnt_ff <= nxt_bit_cnt;
            fb_cnt_ff  <= nxt_fb_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Serializer and retiming
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] shift_ff;
    logic [WORD_W-1:0] nxt_shift;
    logic              serial_ff;
    logic              nxt_serial;
    logic              serial_b_ff;
    logic              load_ff;
    logic              nxt_load;

    // Word is sampled at a fixed divider count, whatever the clock phase,
    // so moving the output clock never moves the capture point
    always_comb
    begin
        if (load_now)
            nxt_shift = parallel_lanes_in;
        else
            nxt_shift = {1'b0, shift_ff[WORD_W-1:1]};
        nxt_serial = shift_ff[0];
        nxt_load   = load_now;
    end

    // Output flop retimes the mux bit on the bit clock
    always_ff @(posedge clock_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            shift_ff    <= '0;
            serial_ff   <= `SST_RST_BIT;
            serial_b_ff <= ~`SST_RST_BIT;
            load_ff     <= `SST_RST_BIT;
        end
        else
        begin
            shift_ff    <= nxt_shift;
            serial_ff   <= nxt_serial;
            serial_b_ff <= ~nxt_serial;
            load_ff     <= nxt_load;
        end
    end

    // ----------------------------------------------------------------
    // Parallel side clock output
    // ----------------------------------------------------------------
    sst_phase_t       phase_sel;
    logic [CNT_W-1:0] phase_off;
    logic [CNT_W-1:0] phase_pos;
    logic             ck_ff;
    logic             nxt_ck;
    logic             ck_b_ff;
    logic             ck_run_ff;
    logic             nxt_ck_run;

    // Select is a static level; a change just slides the edge by quarters
    always_comb
    begin
        phase_sel = sst_phase_t'(clock_phase_select_in);
        unique case (phase_sel)
            SST_PH_0:   phase_off = '0;
            SST_PH_90:  phase_off = CNT_W'(STEP);
            SST_PH_180: phase_off = CNT_W'(2 * STEP);
            SST_PH_270: phase_off = CNT_W'(3 * STEP);
        endcase
        phase_pos  = CNT_W'(nxt_bit_cnt - phase_off);
        // Held low until the first true rising point, so reset leaves no runt pulse
        nxt_ck_run = ck_run_ff || (phase_pos == '0);
        nxt_ck     = nxt_ck_run && ~phase_pos[CNT_W-1];
    end

    // Rising edge lands where the next count equals the phase offset
    always_ff @(posedge clock_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            ck_ff     <= `SST_RST_BIT;
            ck_b_ff   <= ~`SST_RST_BIT;
            ck_run_ff <= `SST_RST_BIT;
        end
        else
        begin
            ck_ff     <= nxt_ck;
            ck_b_ff   <= ~nxt_ck;
            ck_run_ff <= nxt_ck_run;
        end
    end

    // ----------------------------------------------------------------
    // Reference edge and detector
    // ----------------------------------------------------------------
    logic ref_prev_ff;
    logic ref_edge;
    logic pfd_up;
    logic pfd_down;
    logic lock_loss_ff;
    logic nxt_lock_loss;

    // Reference pin is synchronous here, so one flop suffices for the edge
    always_comb
    begin
        ref_edge      = pll_reference_input_in && !ref_prev_ff;
        nxt_lock_loss = pfd_up || pfd_down;
    end

    // Flag starts high: nothing is known to be locked out of reset
    always_ff @(posedge clock_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            ref_prev_ff  <= `SST_RST_BIT;
            lock_loss_ff <= `SST_RST_FLAG;
        end
        else
        begin
            ref_prev_ff  <= pll_reference_input_in;
            lock_loss_ff <= nxt_lock_loss;
        end
    end

    sst_pfd u_pfd
    (
        .clock_in             (clock_in),
        .rst_b_in             (rst_sync_ff),
        .ref_edge_in          (ref_edge),
        .fb_edge_in           (fb_edge),
        .phase_up_pulse_out   (pfd_up),
        .phase_down_pulse_out (pfd_down)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign serial_data_out                  = serial_ff;
    assign serial_data_b_out                = serial_b_ff;
    assign parallel_side_clock_output_out   = ck_ff;
    assign parallel_side_clock_output_b_out = ck_b_ff;
    assign word_load_out                    = load_ff;
    assign phase_up_pulse_out               = pfd_up;
    assign phase_down_pulse_out             = pfd_down;
    assign lock_loss_flag_out               = lock_loss_ff;

endmodule

// ===== test/sst_asic_model.sv
// Purpose: Behavioural system ASIC returning words on the counter clock
// Assumes: Launch delay is fixed, so the round trip never varies
// Notes  : Word sequence is a plain deterministic pattern
`timescale 1ns/10ps

module sst_asic_model
    import sst_pkg::*;
#(
    parameter int LAUNCH_NS = 10
)
(
    input  wire logic        clk_back_in,
    output logic      [15:0] lanes_out
);
    logic [15:0] idx_ff = 16'h0000;

    initial lanes_out = 16'h0000;

    // Launch after the rising edge and hold a whole period; a fixed delay keeps jitter at zero
    always @(posedge clk_back_in)
    begin
        lanes_out <= #(LAUNCH_NS) (idx_ff * 16'h9E37) ^ 16'h5A0F;
        idx_ff    <= idx_ff + 16'h0001;
    end
endmodule

// ===== test/sst_serializer_checker.sv
// Purpose: Port assertions for the serial transmitter
// Assumes: REF_DIV equals WORD_W, so detector feedback edges match loads
// Notes  : Bound to the top module
`timescale 1ns/10ps

module sst_chk
    import sst_pkg::*;
#(
    parameter int WORD_W  = 16,
    parameter int REF_DIV = 16
)
(
    input wire logic              clock_in,
    input wire logic              rst_b_in,
    input wire logic [WORD_W-1:0] parallel_lanes_in,
    input wire logic [1:0]        clock_phase_select_in,
    input wire logic              pll_reference_input_in,
    input wire logic              serial_data_out,
    input wire logic              parallel_side_clock_output_out,
    input wire logic              word_load_out,
    input wire logic              phase_up_pulse_out,
    input wire logic              phase_down_pulse_out,
    input wire logic              lock_loss_flag_out
);
    logic              ck, ld, up, dn, seen_ff, nxt_seen, rq_ff, nxt_rq, re;
    logic [4:0]        gap, dist_ff, nxt_dist;
    logic [WORD_W-1:0] lq_ff, nxt_lq, word_ff, nxt_word;

    assign ck = parallel_side_clock_output_out;
    assign ld = word_load_out;
    assign up = phase_up_pulse_out;
    assign dn = phase_down_pulse_out;

    // Distance from the last load; only the clock span checks are judged before the first load after reset
    always_comb
    begin
        gap      = ld ? 5'h0 : dist_ff;
        nxt_dist = gap + 5'h1;
        nxt_seen = seen_ff | ld;
        nxt_lq   = parallel_lanes_in;
        nxt_word = ld ? lq_ff : word_ff;
        nxt_rq   = pll_reference_input_in;
        re       = pll_reference_input_in & ~rq_ff;   // Reference edge acting at this clock edge
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            seen_ff <= 1'h0;
        else
            seen_ff <= nxt_seen;
    end

    // Data path copies need no reset, they are only read once seen_ff is set
    always_ff @(posedge clock_in)
    begin
        dist_ff <= nxt_dist;
        lq_ff   <= nxt_lq;
        word_ff <= nxt_word;
        rq_ff   <= nxt_rq;
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence s_high8;
        ck [*8] ##1 !ck;
    endsequence
    sequence s_low8;
        (!ck) [*8] ##1 ck;
    endsequence

    // Output clock is a square wave, phase set by select relative to the load pulse
    a_clk_high: assert property ($rose(ck) |-> s_high8)
        else $error("clock output high span wrong");
    a_clk_low: assert property ($fell(ck) |-> s_low8)
        else $error("clock output low span wrong");
    a_clk_phase: assert property ($rose(ck) && seen_ff |-> gap == {1'h0, clock_phase_select_in, 2'h0})
        else $error("clock output phase wrong");
    // One word every sixteen bit clocks, lane 0 first
    a_load_period: assert property (seen_ff |-> (ld ? dist_ff == 5'h10 : dist_ff < 5'h10))
        else $error("load spacing wrong");
    a_serial_order: assert property (seen_ff |-> serial_data_out == word_ff[dist_ff - 5'h1])
        else $error("serial bit wrong");
    // Detector state, feedback edges coincide with loads
    a_up_set: assert property (seen_ff && re && !ld && !dn |=> up)
        else $error("up not set by reference edge");
    a_up_clear: assert property (seen_ff && up && ld |=> !up)
        else $error("up not cleared by feedback edge");
    a_down_set: assert property (seen_ff && ld && !re && !up |=> dn)
        else $error("down not set by feedback edge");
    a_lock_flag: assert property (seen_ff |-> lock_loss_flag_out == $past(up || dn))
        else $error("lock loss flag wrong");
endmodule

bind sst_serializer_top sst_chk #(.WORD_W(WORD_W), .REF_DIV(REF_DIV)) u_sst_chk (
    .clock_in, .rst_b_in, .parallel_lanes_in, .clock_phase_select_in, .pll_reference_input_in,
    .serial_data_out, .parallel_side_clock_output_out, .word_load_out,
    .phase_up_pulse_out, .phase_down_pulse_out, .lock_loss_flag_out);

// ===== test/test_sixteen_to_one_serializer_tx.sv
// Purpose: Self-checking bench for the serial transmitter
// Assumes: REF_DIV of 16, so detector feedback edges fall on word loads
// Notes  : Select changes only under reset, since the select pins are static
`timescale 1ns/10ps

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("Error at %0t: got %0h, expected %0h", $time, a, b); end end

module test_sixteen_to_one_serializer_tx;
    typedef struct { logic [1:0] sel; int rise; } sst_row_t;
    localparam int D = 10;
    logic        clock_in = 1'h0;
    logic        rst_b_in = 1'h0;
    logic [1:0]  sel      = 2'h0;
    logic        ref_in   = 1'h0;
    logic [15:0] lanes, word, lanes_last;
    logic        ser, ser_b, ck, ck_b, load, up, dn, ll, ck_prev, arm;
    int          n_fail, n_tests, k, bi, gap_n, n_up, n_ll;
    sst_row_t    rows [4] = '{'{2'h3, 12}, '{2'h0, 0}, '{2'h2, 8}, '{2'h1, 4}};

    sst_asic_model u_sst_asic_model (.clk_back_in(ck), .lanes_out(lanes));
    sst_serializer_top #(.WORD_W(16), .REF_DIV(16)) u_sst_serializer_top (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .parallel_lanes_in(lanes),
        .clock_phase_select_in(sel), .pll_reference_input_in(ref_in),
        .serial_data_out(ser), .serial_data_b_out(ser_b),
        .parallel_side_clock_output_out(ck), .parallel_side_clock_output_b_out(ck_b),
        .word_load_out(load), .phase_up_pulse_out(up), .phase_down_pulse_out(dn),
        .lock_loss_flag_out(ll));

    always #50 clock_in = ~clock_in;

    task automatic tick();
        @(posedge clock_in);
        #D;
    endtask
    task automatic step(input int n, input logic v);
        repeat (n) tick();
        ref_in = v;
    endtask
    // Stops just after the edge that raises the load pulse
    task automatic sync();
        int n;
        n = 0;
        do
        begin
            ck_prev = ck;
            tick();
            n++;
        end while (load !== 1'h1 && n < 40);
    endtask
    task automatic conclude();
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Stream monitor: the captured word is the lane value one cycle before the load pulse
    always @(posedge clock_in)
    begin
        #D;
        gap_n++;
        if (!rst_b_in)
            arm = 1'h0;
        else
        begin
            `CHK(ck_b, ~ck)
            if (arm && bi < 16)
            begin
                `CHK(ser, word[bi])
                `CHK(ser_b, ~word[bi])
                bi++;
            end
            if (load === 1'h1)
            begin
                if (arm) `CHK(gap_n, 16)
                word  = lanes_last;
                bi    = 0;
                gap_n = 0;
                arm   = 1'h1;
            end
        end
        lanes_last = lanes;
    end

    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            rst_b_in = 1'h0;
            sel      = rows[i].sel;
            repeat (3) tick();
            `CHK({ser, ser_b, ck, ck_b, load, up, dn, ll}, 8'h51)
            rst_b_in = 1'h1;
            sync();
            k = 0;
            while (!(ck === 1'h1 && ck_prev === 1'h0) && k < 20)
            begin
                ck_prev = ck;
                tick();
                k++;
            end
            `CHK(k, rows[i].rise)
            `CHK({up, dn, ll}, 3'h3)
            repeat (48) tick();
        end
        // Clear the lag state, then keep reference edges on the feedback edges
        sync();
        step(10, 1'h1);
        step(2, 1'h0);
        step(4, 1'h1);
        repeat (3)
        begin
            step(8, 1'h0);
            step(8, 1'h1);
        end
        `CHK({up, dn, ll}, 3'h0)
        // Reference four cycles early gives a four cycle up pulse
        step(8, 1'h0);
        step(4, 1'h1);
        for (int i = 0; i < 12; i++)
        begin
            tick();
            if (i == 1)
                ref_in = 1'h0;
            n_up += up;
            n_ll += ll;
        end
        `CHK(n_up, 4)
        `CHK(n_ll, 4)
        conclude();
    end

    // Watchdog at about five times the expected run
    initial
    begin
        #(2000 * 100);
        n_fail++;
        conclude();
    end
endmodule
